// file: tb/radio_logic_receiver_outputs_tb.sv
// Self-checking bench for the radio logic receiver.
`timescale 1ns/10ps
`default_nettype none
module radio_logic_receiver_outputs_tb;
	import rx_logic_pkg::*;
	localparam int HL = 200;
	localparam int HS = 40;
	logic core_clk = 0, reset_n = 0, network_select_strap = 0;
	logic hang_select_strap = 0, mode_strap_high = 1, learnBtn = 0;
	logic serByteValid = 0, hsel = 0, hwrite = 0;
	logic [7:0] serByte = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2, ins = 3'h0;
	logic [31:0] haddr = '0, hwdata = '0, rd, src = 32'h1234_5678;
	logic learn_pin_out, learn_pin_oe, logic_out_one, logic_out_two;
	logic logic_out_three, rxEnable, txEnable, serByteReady;
	logic hreadyout, hresp;
	logic [31:0] hrdata;
	rx_packet_t rxPacket;
	tx_packet_t txPacket;
	int fails = 0, nCompared = 0, cyc = 0;
	// The learn wire follows learnBtn unless the device drives it.
	wire logic learn_pin_in = learn_pin_oe ? learn_pin_out : learnBtn;
	wire logic hready = hreadyout;
	wire logic [2:0] outs = {logic_out_three, logic_out_two, logic_out_one};
	rx_logic_receiver #(.HANG_LONG_CYCLES(HL), .HANG_SHORT_CYCLES(HS),
		.CLOSE_CYCLES(30)) DUT (.*);
	radio_partner #(.PERIOD(30)) P (.core_clk(core_clk), .ins(ins),
		.serial(src), .pkt(rxPacket));
	// Clock and a hang guard.
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			conclude();
		end
	end
	task automatic conclude;
		if (fails == 0 && nCompared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		nCompared++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", n, e, g);
			fails++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// One single word transfer; read data lands in rd.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic pk(input logic [3:0] l, input logic [7:0] s,
		input logic [31:0] sn, input logic [2:0] e);
		P.send(l, src, s, sn);
		tick(1);
		chk("outs", {29'h0, e}, {29'h0, outs});
	endtask
	task automatic t_regs;
		bus(0, 8'h08, '0);
		chk("own", 32'h5A5A_0001, rd);
		bus(1, 8'h08, 32'hCAFE_0005);
		bus(0, 8'h08, '0);
		chk("own wr", 32'hCAFE_0005, rd);
		bus(1, 8'h0C, 32'hFFFF_FFFF);
		bus(0, 8'h0C, '0);
		chk("learned ro", '0, rd);
		bus(0, 8'h40, '0);
		chk("unmapped", '0, rd);
		bus(0, 8'h04, '0);
		chk("status", 32'h0000_0100, rd);
	endtask
	task automatic t_serial;
		chk("ready rx", 32'h0, {31'h0, serByteReady});
		mode_strap_high <= 1'b0;
		tick(4);
		chk("tx en", 32'h1, {31'h0, txEnable});
		chk("rx en", 32'h1, {31'h0, rxEnable});
		chk("ready ser", 32'h1, {31'h0, serByteReady});
		// Twelve bytes back to back close a packet at once.
		for (int i = 0; i < 12; i++) begin
			serByteValid <= 1'b1;
			serByte <= 8'hA0 + 8'(i);
			tick(1);
		end
		serByteValid <= 1'b0;
		tick(1);
		chk("full valid", 32'h1, {31'h0, txPacket.valid});
		chk("full len", 32'hC, {28'h0, txPacket.len});
		chk("full first", 32'hA0, {24'h0, txPacket.data[0]});
		chk("full last", 32'hAB, {24'h0, txPacket.data[11]});
		// A lone byte waits for the close timer.
		serByteValid <= 1'b1;
		serByte <= 8'h5C;
		tick(1);
		serByteValid <= 1'b0;
		tick(30);
		chk("early close", 32'h0, {31'h0, txPacket.valid});
		tick(1);
		chk("timed valid", 32'h1, {31'h0, txPacket.valid});
		chk("timed len", 32'h1, {28'h0, txPacket.len});
		chk("timed byte", 32'h5C, {24'h0, txPacket.data[0]});
		mode_strap_high <= 1'b1;
		tick(4);
	endtask
	task automatic t_open;
		for (int i = 0; i < 8; i++) begin
			pk(1, {1'b0, i[2:0], 4'h0}, '0, i[2:0]);
		end
		pk(1, 8'h30, '0, 3'h3);
		tick(HS - 4);
		pk(1, 8'h30, '0, 3'h3);
		tick(HS - 4);
		chk("hold", 32'h3, {29'h0, outs});
		tick(8);
		chk("clear", 32'h0, {29'h0, outs});
		pk(1, 8'h70, '0, 3'h7);
		pk(1, 8'h00, '0, 3'h0);
		pk(1, 8'h60, '0, 3'h6);
		pk(1, 8'h78, '0, 3'h6);
		pk(3, 8'h70, '0, 3'h6);
		pk(1, 8'h21, '0, 3'h2);
		pk(1, 8'h00, '0, 3'h0);
	endtask
	task automatic t_long;
		hang_select_strap <= 1'b1;
		tick(4);
		pk(5, 8'h50, src, 3'h5);
		tick(HL - 5);
		chk("long hold", 32'h5, {29'h0, outs});
		tick(8);
		chk("long clear", 32'h0, {29'h0, outs});
		hang_select_strap <= 1'b0;
		ins <= 3'h6;
		tick(100);
		chk("tx held", 32'h6, {29'h0, outs});
		ins <= 3'h0;
		tick(HS + 35);
		chk("tx idle", 32'h0, {29'h0, outs});
	endtask
	task automatic t_net;
		network_select_strap <= 1'b1;
		tick(4);
		pk(5, 8'h20, 32'hCAFE_0005, 3'h2);
		pk(1, 8'h70, '0, 3'h2);
		pk(5, 8'h40, 32'h1111_2222, 3'h2);
		bus(1, 8'h00, 32'h1);
		tick(2);
		chk("learn oe", 32'h1, {31'h0, learn_pin_oe});
		pk(5, 8'h70, 32'h9999_0000, 3'h2);
		tick(6);
		bus(0, 8'h0C, '0);
		chk("learned", src, rd);
		pk(1, 8'h10, '0, 3'h1);
		pk(1, 8'h00, '0, 3'h0);
		// A press on the learn pin starts learning again.
		learnBtn <= 1'b1;
		tick(5);
		chk("pin learn", 32'h1, {31'h0, learn_pin_oe});
		learnBtn <= 1'b0;
		network_select_strap <= 1'b0;
	endtask
	initial begin
		tick(12);
		reset_n <= 1'b1;
		tick(4);
		t_regs();
		t_serial();
		t_open();
		t_long();
		t_net();
		conclude();
	end
endmodule
`default_nettype wire

// file: tb/radio_partner.sv
// Behavioural remote logic transmitter feeding received packets.
`timescale 1ns/10ps
`default_nettype none
module radio_partner
	import rx_logic_pkg::*;
#(
	parameter int PERIOD = 30
) (
	input wire logic core_clk,
	input wire logic [2:0] ins,
	input wire logic [31:0] serial,
	output rx_packet_t pkt
);
	int cnt = 0;
	initial pkt = '0;
	// One packet for one cycle; the lines then show junk, not old data.
	task automatic send(input logic [3:0] l, input logic [31:0] hdr,
		input logic [7:0] st, input logic [31:0] sn);
		pkt <= {1'b1, l, hdr, sn[7:0], sn[15:8], sn[23:16], sn[31:24],
			st};
		@(posedge core_clk);
		pkt <= {1'b0, ~l, ~hdr, ~pkt.data};
	endtask
	// Silent while all inputs are low, else repeats the state.
	always @(posedge core_clk) begin
		cnt <= ins == 3'h0 ? 0 : cnt + 1;
		if (ins != 3'h0 && cnt % PERIOD == 0) begin
			send(4'h5, serial, {1'b0, ins, 4'h0}, serial);
		end
	end
endmodule
`default_nettype wire

// file: tb/rx_logic_chk.sv
// Concurrent checks on the logic receiver's ports.
`timescale 1ns/10ps
`default_nettype none
module rx_logic_chk
	import rx_logic_pkg::*;
#(
	parameter int unsigned HANG_LONG_CYCLES = 200
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic network_select_strap,
	input wire logic mode_strap_high,
	input wire logic learn_pin_out,
	input wire logic learn_pin_oe,
	input wire logic logic_out_one,
	input wire logic logic_out_two,
	input wire logic logic_out_three,
	input wire logic txEnable,
	input wire rx_packet_t rxPacket,
	input wire tx_packet_t txPacket,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata
);
	logic [2:0] outs;
	logic bad;
	logic [31:0] idle_q;
	// Cycles since the last offered packet; rejected ones restart it too.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			idle_q <= '0;
		end else begin
			idle_q <= rxPacket.valid ? '0 : idle_q + 32'h1;
		end
	end
	// Output vector and the malformed-packet test.
	assign outs = {logic_out_three, logic_out_two, logic_out_one};
	assign bad = (rxPacket.data[0] & 8'h8E) != 8'h00 ||
		(rxPacket.len != 4'h1 && rxPacket.len != 4'h5);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence s_open_pkt;
		rxPacket.valid && rxPacket.len == 4'h1 && !bad &&
			!network_select_strap && mode_strap_high && !learn_pin_oe;
	endsequence
	a_open_accept: assert property (
		s_open_pkt |=> outs == $past(rxPacket.data[0][6:4]))
		else $error("open packet not shown");
	a_hang_ends: assert property (
		idle_q > HANG_LONG_CYCLES + 2 |-> outs == 3'h0)
		else $error("outputs outlived hang time");
	a_drop_hold: assert property (
		rxPacket.valid && bad |=> $stable(outs))
		else $error("malformed packet moved outputs");
	a_out_cause: assert property (
		$changed(outs) && outs != 3'h0 |-> $past(rxPacket.valid))
		else $error("outputs set without packet");
	a_no_send: assert property (
		mode_strap_high && $past(mode_strap_high, 3) |->
			!txEnable && !txPacket.valid)
		else $error("receiver transmitted");
	a_learn_drive: assert property (
		$rose(learn_pin_oe) |-> network_select_strap && learn_pin_out)
		else $error("learn pin driven wrongly");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus stalled or errored");
	a_rdata_idle: assert property (
		!$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == '0)
		else $error("read data outside data phase");
endmodule
bind rx_logic_receiver rx_logic_chk #(
	.HANG_LONG_CYCLES(HANG_LONG_CYCLES)) chk (.*);
`default_nettype wire

// file: verilog/rx_logic_defines.svh
// Shared constants: register map, field positions, packet layout, timing.
`ifndef RX_LOGIC_DEFINES_SVH
`define RX_LOGIC_DEFINES_SVH

// Clock rate and printed times in milliseconds.
`define CLK_HZ 100_000_000
`define MS_PER_S 1000
`define HANG_LONG_MS 500
`define HANG_SHORT_MS 20
`define CLOSE_MS 15

// Counter widths sized for the longest default count.
`define HANG_W 26
`define CLOSE_W 21

// Packet layout.
`define RX_MAX_BYTES 5
`define TX_MAX_BYTES 12
`define TX_CNT_W 4
`define LEN_W 4
`define LEN_CMD_SHORT 4'h1
`define LEN_CMD_LONG 4'h5
`define TX_FULL 4'hC
`define BIT_IN1 4
`define BIT_IN3 6
`define STATE_RSVD_MASK 8'h8E
`define STATE_ALL_OFF 8'h00

// Register byte offsets, low address byte only.
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_OWN_SERIAL 8'h08
`define REG_LEARNED_SERIAL 8'h0C

// Control register bits.
`define CTRL_LEARN 0
`define CTRL_FORGET 1

// Status register bits.
`define ST_OUT_LO 0
`define ST_OUT_HI 2
`define ST_NETWORK 4
`define ST_HANG_LONG 5
`define ST_LEARNING 6
`define ST_LEARNED 7
`define ST_RECEIVER 8
`define ST_HANG_ACTIVE 9

// Bus encodings.
`define HSIZE_WORD 3'h2
`define HTRANS_ACTIVE 1
`define HRESP_OKAY 1'h0

`endif

// file: verilog/rx_logic_pkg.sv
// Types shared by the logic receiver and its serial packet closer.
package rx_logic_pkg;
`include "rx_logic_defines.svh"

	// A received radio packet; data[0] is the first payload byte.
	typedef struct packed {
		logic valid;
		logic [`LEN_W-1:0] len;
		logic [31:0] hdrSerial;
		logic [`RX_MAX_BYTES-1:0][7:0] data;
	} rx_packet_t;

	// A radio packet closed by the serial path; data[0] goes first.
	typedef struct packed {
		logic valid;
		logic [`LEN_W-1:0] len;
		logic [`TX_MAX_BYTES-1:0][7:0] data;
	} tx_packet_t;

	typedef enum logic [2:0] {
		LS_IDLE = 3'h1,
		LS_LEARN = 3'h2,
		LS_RELEASE = 3'h4
	} learn_state_t;

	typedef enum logic [1:0] {
		CS_EMPTY = 2'h1,
		CS_FILL = 2'h2
	} close_state_t;

	typedef struct packed {
		close_state_t state;
		logic [`TX_CNT_W-1:0] count;
		logic [`CLOSE_W-1:0] timer;
		logic [`TX_MAX_BYTES-1:0][7:0] data;
		tx_packet_t pkt;
		logic ready;
	} close_state_s_t;

	typedef struct packed {
		logic netMeta;
		logic network;
		logic hangMeta;
		logic hangSel;
		logic modeMeta;
		logic modeRecv;
		logic learnMeta;
		logic learnIn;
		logic learnPrev;
		learn_state_t learnState;
		logic learnOut;
		logic learnOe;
		logic learnedValid;
		logic [31:0] learnedSerial;
		logic [31:0] ownSerial;
		logic [2:0] outs;
		logic [`HANG_W-1:0] hangCnt;
		logic dataWrite;
		logic [7:0] addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		logic rxEnable;
		logic txEnable;
	} rx_state_t;

endpackage

// file: verilog/rx_logic_receiver.sv
// Logic receiver: packet filter, output drive, hang timer, bus registers.
//
// Contract
// - Receiver modes only receive, never transmit.
// - Network strap high selects network mode.
// - Learn pin bidirectional only in network mode.
// - Packet bits drive three active-high outputs.
// - Hang time 500ms or 20ms, then clear.
// - State bits 6..4 carry inputs 3..1.
// - Bit 0 RFID flag, other bits zero.
// - State byte then four serial bytes.
// - Network mode discards unlearned senders; the code accepts a five-byte command matching own serial from any sender.
// - Serial-module packets decode like transmitter packets.
// - Single zero byte clears outputs immediately.
// - One-byte command needs learned header serial.
// - Open mode accepts every packet; the code still drops malformed packets and lengths other than 1 or 5.
// - Five-byte command needs own serial match.
// - Learning stores header serial only.
// - Sender closes packet at 12 bytes/15ms.
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "rx_logic_defines.svh"
module rx_logic_receiver
	import rx_logic_pkg::*;
#(
	parameter int unsigned HANG_LONG_CYCLES =
		`CLK_HZ / `MS_PER_S * `HANG_LONG_MS,
	parameter int unsigned HANG_SHORT_CYCLES =
		`CLK_HZ / `MS_PER_S * `HANG_SHORT_MS,
	parameter int unsigned CLOSE_CYCLES = `CLK_HZ / `MS_PER_S * `CLOSE_MS,
	parameter bit HANG_LONG_LEVEL = 1'b1,
	// Reset value of the unit serial number; arbitrary.
	parameter logic [31:0] UNIT_SERIAL_DEFAULT = 32'h5A5A_0001
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic network_select_strap,
	input wire logic hang_select_strap,
	input wire logic mode_strap_high,
	input wire logic learn_pin_in,
	output logic learn_pin_out,
	output logic learn_pin_oe,
	output logic logic_out_one,
	output logic logic_out_two,
	output logic logic_out_three,
	output logic rxEnable,
	output logic txEnable,
	input wire rx_packet_t rxPacket,
	input wire logic serByteValid,
	input wire logic [7:0] serByte,
	output logic serByteReady,
	output tx_packet_t txPacket,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);

	// A state byte is legal when only input and RFID bits are set.
	function automatic logic formatOk(input logic [7:0] b);
		formatOk = (b & `STATE_RSVD_MASK) == `STATE_ALL_OFF;
	endfunction

	// Input bits of a state byte, in output order one to three.
	function automatic logic [2:0] outBits(input logic [7:0] b);
		outBits = b[`BIT_IN3:`BIT_IN1];
	endfunction

	logic [1:0] rstPipe;
	logic rstN;
	rx_state_t s;
	rx_state_t n;
	logic take;
	logic isShort;
	logic isLong;
	logic hdrKnown;
	logic accept;
	logic hangLong;
	logic swLearn;
	logic swForget;
	logic [31:0] payloadSerial;
	logic [31:0] rdVal;

	// Reset release is synchronised so every flop leaves reset together.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstPipe <= 2'h0;
		end else begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rstN = rstPipe[1];

	// All outputs come from state flops.
	assign learn_pin_out = s.learnOut;
	assign learn_pin_oe = s.learnOe;
	assign logic_out_one = s.outs[0];
	assign logic_out_two = s.outs[1];
	assign logic_out_three = s.outs[2];
	assign rxEnable = s.rxEnable;
	assign txEnable = s.txEnable;
	assign hreadyout = s.hreadyout;
	assign hresp = s.hresp;
	assign hrdata = s.hrdata;

	// Next-state logic for pins, filtering, learning, timer and bus.
	always_comb begin
		n = s;
		// Strap and pin synchronisers, two flops each.
		n.netMeta = network_select_strap;
		n.network = s.netMeta;
		n.hangMeta = hang_select_strap;
		n.hangSel = s.hangMeta;
		n.modeMeta = mode_strap_high;
		n.modeRecv = s.modeMeta;
		n.learnMeta = learn_pin_in;
		n.learnIn = s.learnMeta;
		n.learnPrev = s.learnIn;
		n.hresp = `HRESP_OKAY;
		n.hreadyout = 1'b1;
		// Receiver modes keep the radio listening and never send.
		n.rxEnable = 1'b1;
		n.txEnable = !s.modeRecv;
		hangLong = s.hangSel == HANG_LONG_LEVEL;

		// Bus data phase: writes land one cycle after the address phase.
		swLearn = 1'b0;
		swForget = 1'b0;
		if (s.dataWrite) begin
			case (s.addr)
				`REG_CTRL: begin
					swLearn = hwdata[`CTRL_LEARN];
					swForget = hwdata[`CTRL_FORGET];
				end
				`REG_OWN_SERIAL: begin
					n.ownSerial = hwdata;
				end
				default: begin
				end
			endcase
		end
		if (swForget) begin
			n.learnedValid = 1'b0;
		end

		// Sender filter. A serial-module packet uses the same layout.
		isShort = rxPacket.len == `LEN_CMD_SHORT;
		isLong = rxPacket.len == `LEN_CMD_LONG;
		payloadSerial = {rxPacket.data[1], rxPacket.data[2],
			rxPacket.data[3], rxPacket.data[4]};
		hdrKnown = s.learnedValid && rxPacket.hdrSerial == s.learnedSerial;
		if (!s.network) begin
			accept = 1'b1;
		end else if (isShort) begin
			accept = hdrKnown;
		end else begin
			// A transmitter repeats its own serial in the payload; a
			// five-byte command names the addressed receiver instead.
			accept = payloadSerial == s.ownSerial ||
				(hdrKnown && payloadSerial == rxPacket.hdrSerial);
		end
		accept = accept && rxPacket.valid && (isShort || isLong) &&
			formatOk(rxPacket.data[0]) && s.learnState != LS_LEARN &&
			s.modeRecv;

		// Learn sequence, only while the network strap is high.
		case (s.learnState)
			LS_IDLE: begin
				if (s.network && ((s.learnIn && !s.learnPrev) || swLearn)) begin
					n.learnState = LS_LEARN;
				end
			end
			LS_LEARN: begin
				if (!s.network) begin
					n.learnState = LS_IDLE;
				end else if (rxPacket.valid && (isShort || isLong)) begin
					n.learnedSerial = rxPacket.hdrSerial;
					n.learnedValid = 1'b1;
					n.learnState = LS_RELEASE;
				end
			end
			LS_RELEASE: begin
				// Wait for the button to let go so it cannot relearn.
				if (!s.learnIn || !s.network) begin
					n.learnState = LS_IDLE;
				end
			end
			default: begin
				n.learnState = LS_IDLE;
			end
		endcase
		// The pin lights while learning and floats otherwise.
		n.learnOut = n.learnState == LS_LEARN;
		n.learnOe = n.learnState == LS_LEARN;

		// Hang timer: outputs fall when the count runs out.
		if (s.hangCnt != '0) begin
			n.hangCnt = s.hangCnt - `HANG_W'(1);
			if (s.hangCnt == `HANG_W'(1)) begin
				n.outs = 3'h0;
			end
		end
		if (accept) begin
			if (isShort && rxPacket.data[0] == `STATE_ALL_OFF) begin
				n.outs = 3'h0;
				n.hangCnt = '0;
			end else begin
				n.outs = outBits(rxPacket.data[0]);
				// Reload even when the state is unchanged.
				n.hangCnt = hangLong ? `HANG_W'(HANG_LONG_CYCLES) :
					`HANG_W'(HANG_SHORT_CYCLES);
			end
		end
		if (!s.modeRecv) begin
			n.outs = 3'h0;
			n.hangCnt = '0;
		end

		// Bus address phase: read data is prepared for the data phase.
		take = hsel && htrans[`HTRANS_ACTIVE] && hready;
		n.dataWrite = take && hwrite && hsize == `HSIZE_WORD;
		n.addr = haddr[7:0];
		rdVal = '0;
		case (haddr[7:0])
			`REG_CTRL: begin
				rdVal[`CTRL_LEARN] = s.learnState == LS_LEARN;
			end
			`REG_STATUS: begin
				rdVal[`ST_OUT_HI:`ST_OUT_LO] = s.outs;
				rdVal[`ST_NETWORK] = s.network;
				rdVal[`ST_HANG_LONG] = hangLong;
				rdVal[`ST_LEARNING] = s.learnState == LS_LEARN;
				rdVal[`ST_LEARNED] = s.learnedValid;
				rdVal[`ST_RECEIVER] = s.modeRecv;
				rdVal[`ST_HANG_ACTIVE] = s.hangCnt != '0;
			end
			`REG_OWN_SERIAL: begin
				rdVal = s.ownSerial;
			end
			`REG_LEARNED_SERIAL: begin
				rdVal = s.learnedSerial;
			end
			default: begin
				rdVal = '0;
			end
		endcase
		n.hrdata = (take && !hwrite) ? rdVal : 32'h0000_0000;
	end

	// State register; bus ready and the serial number have own reset values.
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			s <= '0;
			s.learnState <= LS_IDLE;
			s.hreadyout <= 1'b1;
			s.ownSerial <= UNIT_SERIAL_DEFAULT;
			// The mode sync leaves reset in receiver mode, so the
			// transmitter cannot blip on while the strap settles.
			s.modeMeta <= 1'b1;
			s.modeRecv <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// Serial-mode packetizer; refuses bytes in the receiver modes.
	serial_packet_closer #(
		.CLOSE_CYCLES(CLOSE_CYCLES)
	) closer (
		.core_clk(core_clk),
		.rstN(rstN),
		.enable(!s.modeRecv),
		.byteValid(serByteValid),
		.byteData(serByte),
		.byteReady(serByteReady),
		.pkt(txPacket)
	);

endmodule
`default_nettype wire

// file: verilog/serial_packet_closer.sv
// Serial path packetizer: closes a radio packet on a full or timed buffer.
`timescale 1ns/10ps
`default_nettype none
`include "rx_logic_defines.svh"
module serial_packet_closer
	import rx_logic_pkg::*;
#(
	parameter int unsigned CLOSE_CYCLES = `CLK_HZ / `MS_PER_S * `CLOSE_MS
) (
	input wire logic core_clk,
	input wire logic rstN,
	input wire logic enable,
	input wire logic byteValid,
	input wire logic [7:0] byteData,
	output logic byteReady,
	output tx_packet_t pkt
);

	close_state_s_t s;
	close_state_s_t n;
	logic take;

	assign byteReady = s.ready;
	assign pkt = s.pkt;

	// The timer runs from the first byte, so a steady trickle of bytes
	// cannot hold a packet open forever.
	always_comb begin
		n = s;
		n.pkt.valid = 1'b0;
		n.ready = enable;
		take = s.ready && byteValid;
		case (s.state)
			CS_EMPTY: begin
				if (take) begin
					n.data[0] = byteData;
					n.count = `TX_CNT_W'(1);
					n.timer = `CLOSE_W'(CLOSE_CYCLES);
					n.state = CS_FILL;
				end
			end
			CS_FILL: begin
				n.timer = s.timer - `CLOSE_W'(1);
				if (take) begin
					n.data[s.count] = byteData;
					n.count = s.count + `TX_CNT_W'(1);
				end
				// Full buffer or expired timer, whichever comes first.
				if (n.count == `TX_FULL || s.timer == `CLOSE_W'(1)) begin
					n.pkt.valid = 1'b1;
					n.pkt.len = n.count;
					n.pkt.data = n.data;
					n.count = '0;
					n.state = CS_EMPTY;
				end
			end
			default: begin
				n.state = CS_EMPTY;
			end
		endcase
		// Leaving serial mode drops a half-built packet.
		if (!enable) begin
			n.state = CS_EMPTY;
			n.count = '0;
		end
	end

	// State register.
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			s <= '0;
			s.state <= CS_EMPTY;
		end else begin
			s <= n;
		end
	end

endmodule
`default_nettype wire
